//--- inc/cnem_defs.vh
`ifndef CNEM_DEFS_VH
`define CNEM_DEFS_VH
// object indices reached by the service-data path
`define CNEM_IDX_ERR_SUMMARY 16'h1001
`define CNEM_IDX_ERR_HISTORY 16'h1003
`define CNEM_IDX_ERR_CLEAR 16'h5000
`define CNEM_IDX_PDO_CFG 16'h5f00
`define CNEM_HIST_DEPTH 4'ha
`define CNEM_HIST_SUBMAX 8'h0a
`define CNEM_HIST_SUBCNT 8'h00
`define CNEM_COBID_OFF 32'h80000000
`define CNEM_DIG_PER_OBJ 4'h8
`define CNEM_ANA_MAX 4'h4
`define CNEM_CLEAR_ALL 16'hffff
// frame identifiers
`define CNEM_EMCY_BASE 11'h080
`define CNEM_RX1_BASE 11'h200
`define CNEM_RX2_BASE 11'h300
`define CNEM_RX3_BASE 11'h22a
`define CNEM_RX4_BASE 11'h32a
`define CNEM_RX5_BASE 11'h254
`define CNEM_TX1_BASE 11'h180
`define CNEM_TX2_BASE 11'h280
`define CNEM_TX3_BASE 11'h1aa
`define CNEM_TX4_BASE 11'h2aa
`define CNEM_TX5_BASE 11'h1d4
`define CNEM_TX6_BASE 11'h2d4
`define CNEM_NODE_MAX 7'h2a
// error codes and summary bits
`define CNEM_CODE_NONE 16'h0000
`define CNEM_CODE_GENERIC 16'h1000
`define CNEM_SUM_GENERIC 0
`define CNEM_SUM_COMM 4
`define CNEM_SUM_MANUF 7
`define CNEM_CPU_NEWCFG 7
`define CNEM_MOD_LIFEGUARD 4
// startup frame content
`define CNEM_NEWCFG_CPU 8'h80
`define CNEM_NEWCFG_SUM 8'h01
`define CNEM_LEN_OK 3'h3
`define CNEM_LEN_FULL 3'h5
`define CNEM_FIFO_W 54
`define CNEM_FIFO_D 32
`define CNEM_FIFO_AW 5
`endif

//--- src/cnem_fifo.v
`timescale 1ns/1ps
module cnem_fifo #(
  parameter W = 43,
  parameter D = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // write side
  input wire i_valid,
  output wire o_ready,
  input wire [W-1:0] i_data,
  // read side
  output wire o_valid,
  input wire i_ready,
  output reg [W-1:0] o_data
);
  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire wr = i_valid && o_ready;
  wire rd = o_valid && i_ready;
  assign o_ready = (cnt_q != D[AW:0]);
  assign o_valid = (cnt_q != {(AW+1){1'b0}});
  // storage written without reset; pointers define validity
  always @(posedge i_mclk)
  begin
    if (wr)
      mem_q[wp_q] <= i_data;
  end
  always @*
  begin
    o_data = mem_q[rp_q];
  end
  // pointer and count bookkeeping
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (wr)
        wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      if (rd)
        rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      if (wr && !rd)
        cnt_q <= cnt_q + 1'b1;
      else if (rd && !wr)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // cnem_fifo

//--- src/cnem_top.v
// Operation
// - emergency frames allowed operational and pre-operational
// - emergency identifier is 0x080 plus node
// - summary object holds latest error state
// - ten newest states kept, newest first
// - clean start sends three zero bytes
// - new configuration start sends five fixed bytes
// - new configuration recomputes and stores defaults
// - frame bytes: code, summary, processor, module
// - code zero without error, 0x1000 generic
// - summary bits generic through manufacturer
// - processor detail bits as listed
// - module detail bits and life-guard timeout
// - history word: processor, module, code
// - clear object clears flags, all-ones clears bus
// - five receive, six transmit, five remote
// - receive identifiers default node plus bases
// - transmit identifiers default node plus bases
// - top identifier bit disables unused objects
// - digital outputs one byte, ninth to second
// - analog outputs from object two, four max
// - inputs mirror, four-channel analog first; transmit side has no ninth-input spill or four cap
// - transmit six refuses remote, maps fault words
`timescale 1ns/1ps
`include "cnem_defs.vh"
module cnem_top (
  // clock and reset
  input wire i_mclk,
  input wire i_nrst,
  // node state and identity
  input wire [6:0] i_node_id,
  input wire i_node_operational,
  input wire i_node_preop,
  // start-up status from configuration scan
  input wire i_startup_done,
  input wire i_config_changed,
  input wire [1:0] i_slots_dig_out,
  input wire [3:0] i_cnt_dig_out,
  input wire [3:0] i_cnt_dig_in,
  input wire [3:0] i_cnt_ana_out,
  input wire [3:0] i_cnt_ana_in4,
  input wire [3:0] i_cnt_ana_in2,
  // error events, one-cycle pulses
  input wire [7:0] i_cpu_err_set,
  input wire [4:0] i_mod_err_set,
  input wire i_bus_err_set,
  // object access from the service-data path
  input wire i_obj_wr,
  input wire i_obj_rd,
  input wire [15:0] i_obj_index,
  input wire [7:0] i_obj_sub,
  input wire [31:0] i_obj_wdata,
  output reg [31:0] o_obj_rdata,
  output reg o_obj_ack,
  output reg o_obj_err,
  // emergency frame stream towards the controller
  output wire o_emcy_valid,
  input wire i_emcy_ready,
  output wire [10:0] o_emcy_id,
  output wire [2:0] o_emcy_len,
  output wire [39:0] o_emcy_data,
  output wire o_emcy_overflow,
  // default process-data setup
  output reg o_defaults_store,
  output reg [31:0] o_rx_cobid_flat0,
  output reg [31:0] o_rx_cobid_flat1,
  output reg [31:0] o_tx_cobid_flat0,
  output reg [31:0] o_tx_cobid_flat1,
  output reg [3:0] o_rx_map_ana_first,
  output reg [3:0] o_tx_map_ana_first,
  output wire [4:0] o_tx_rtr_allowed
);
  reg rs1_q;
  reg rst_n_q;
  reg [7:0] cpu_q;
  reg [4:0] mod_q;
  reg bus_q;
  reg [31:0] hist_q [0:9];
  reg [3:0] hcnt_q;
  reg start_q;
  reg sent_q;
  reg [7:0] cpu_d;
  reg [4:0] mod_d;
  reg bus_d;
  reg push;
  reg [15:0] clr;
  wire [7:0] summary;
  wire [15:0] code;
  wire any_err;
  wire f_ready;
  wire [53:0] f_in;
  // summary byte fields, one wire per condition
  wire sum_generic;
  wire sum_current;
  wire sum_voltage;
  wire sum_temperature;
  wire sum_comm;
  wire sum_profile;
  wire sum_reserved;
  wire sum_manuf;
  // event frame summary, built from the next-state flags
  wire [7:0] ev_summary;
  wire ev_comm;
  // new history word
  wire [31:0] hist_new;
  // frame bytes in send order
  wire [7:0] byte_code_hi;
  wire [7:0] byte_code_lo;
  wire [7:0] byte_summary;
  wire [7:0] byte_cpu;
  wire [7:0] byte_module;
  wire [10:0] emcy_id;
  wire [10:0] node_ext;
  wire f_wr;
  // default identifiers for the first two objects each way
  wire [10:0] rx1_id;
  wire [10:0] rx2_id;
  wire [10:0] tx1_id;
  wire [10:0] tx2_id;
  // disable bits for objects with nothing mapped
  wire rx1_off;
  wire rx2_off;
  wire tx1_off;
  wire tx2_off;
  wire [3:0] ana_out_used;
  // history read decode
  wire hist_sel;
  wire hist_cnt_sel;
  wire hist_ent_sel;
  wire [3:0] hist_slot;
  wire can_send;
  reg [2:0] ev_len;
  reg [39:0] ev_data;
  integer k;
  // reset release through two flops; assertion stays asynchronous,
  // release is clean against the clock so no flop sees a half-edge
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rs1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rs1_q <= 1'b1;
      rst_n_q <= rs1_q;
    end
  end
  // clear mask from the clear object; all ones also clears bus flag
  always @*
  begin
    clr = 16'h0000;
    if (i_obj_wr && i_obj_index == `CNEM_IDX_ERR_CLEAR)
      clr = i_obj_wdata[15:0];
  end
  // sticky flags: a set in the clear cycle wins
  always @*
  begin
    cpu_d = (cpu_q & ~clr[15:8]) | i_cpu_err_set;
    mod_d = (mod_q & ~{1'b0, clr[3:0]}) | i_mod_err_set;
    if (clr == `CNEM_CLEAR_ALL)
      mod_d[`CNEM_MOD_LIFEGUARD] = i_mod_err_set[`CNEM_MOD_LIFEGUARD];
    bus_d = (bus_q && clr != `CNEM_CLEAR_ALL) || i_bus_err_set;
    push = (|i_cpu_err_set) || (|i_mod_err_set) || i_bus_err_set;
  end
  assign any_err = (|cpu_q) || (|mod_q) || bus_q;
  // summary bits laid out generic..manufacturer; only generic and
  // communication conditions are tracked here, the rest read as zero
  assign sum_generic = any_err;
  assign sum_current = 1'b0;
  assign sum_voltage = 1'b0;
  assign sum_temperature = 1'b0;
  // a life-guarding timeout is a communication fault as well
  assign sum_comm = bus_q | mod_q[`CNEM_MOD_LIFEGUARD];
  assign sum_profile = 1'b0;
  assign sum_reserved = 1'b0;
  // maker-specific causes live in the detail bytes, so this bit stays low,
  // matching the new-configuration start frame
  assign sum_manuf = 1'b0;
  assign summary = {sum_manuf, sum_reserved, sum_profile, sum_comm, sum_temperature, sum_voltage, sum_current,
    sum_generic};
  // history word: processor byte on top, then module byte, then code
  assign hist_new = {cpu_d, 3'b000, mod_d, `CNEM_CODE_GENERIC};
  assign code = any_err ? `CNEM_CODE_GENERIC : `CNEM_CODE_NONE;
  // history and flag state
  always @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cpu_q <= 8'h00;
      mod_q <= 5'h00;
      bus_q <= 1'b0;
      hcnt_q <= 4'h0;
      for (k = 0; k < 10; k = k + 1)
        hist_q[k] <= 32'h00000000;
    end
    else
    begin
      cpu_q <= cpu_d;
      mod_q <= mod_d;
      bus_q <= bus_d;
      if (push)
      begin
        for (k = 9; k > 0; k = k - 1)
          hist_q[k] <= hist_q[k-1];
        hist_q[0] <= hist_new;
        if (hcnt_q != `CNEM_HIST_DEPTH)
          hcnt_q <= hcnt_q + 4'h1;
      end
    end
  end
  // event frames describe the state after this cycle's sets
  assign ev_comm = bus_d | mod_d[`CNEM_MOD_LIFEGUARD];
  assign ev_summary = {3'b000, ev_comm, 3'b000, 1'b1};
  // emergency frame build; start-up frame or error event
  always @*
  begin
    ev_len = `CNEM_LEN_FULL;
    ev_data = {code, summary, cpu_d, 3'b000, mod_d};
    if (start_q && !i_config_changed)
    begin
      ev_len = `CNEM_LEN_OK;
      ev_data = 40'h0;
    end
    else if (start_q)
      ev_data = {`CNEM_CODE_GENERIC, `CNEM_NEWCFG_SUM, `CNEM_NEWCFG_CPU, 8'h00};
    else if (push)
      ev_data = {`CNEM_CODE_GENERIC, ev_summary, cpu_d, 3'b000, mod_d};
  end
  // split into bytes in send order, first byte on top
  assign byte_code_hi = ev_data[39:32];
  assign byte_code_lo = ev_data[31:24];
  assign byte_summary = ev_data[23:16];
  assign byte_cpu = ev_data[15:8];
  assign byte_module = ev_data[7:0];
  // node number widened once, shared by every identifier sum
  assign node_ext = {4'h0, i_node_id};
  assign emcy_id = `CNEM_EMCY_BASE + node_ext;
  // frames are only queued in the two states that may send
  assign can_send = i_node_operational || i_node_preop;
  assign f_wr = can_send && (start_q || push);
  assign f_in = {emcy_id, ev_len, byte_code_hi, byte_code_lo, byte_summary, byte_cpu, byte_module};
  // a full queue drops the event; the flag lets the host count losses
  assign o_emcy_overflow = f_wr && !f_ready;
  // start-up pulse: one frame per reset on the first done cycle;
  // the done level stays high, so a sent flag keeps it from repeating
  always @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      start_q <= 1'b0;
      sent_q <= 1'b0;
    end
    else
    begin
      start_q <= i_startup_done && !sent_q;
      sent_q <= sent_q || i_startup_done;
    end
  end
  // frame queue; storage only, no reordering
  cnem_fifo #(
    .W(`CNEM_FIFO_W),
    .D(`CNEM_FIFO_D),
    .AW(`CNEM_FIFO_AW)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n_q),
    .i_valid(f_wr),
    .o_ready(f_ready),
    .i_data(f_in),
    .o_valid(o_emcy_valid),
    .i_ready(i_emcy_ready),
    .o_data({o_emcy_id, o_emcy_len, o_emcy_data})
  );
  // first five transmit objects answer remote requests, the sixth never
  assign o_tx_rtr_allowed = 5'h1f;
  // identifiers for the default objects, node number added to each base
  assign rx1_id = `CNEM_RX1_BASE + node_ext;
  assign rx2_id = `CNEM_RX2_BASE + node_ext;
  assign tx1_id = `CNEM_TX1_BASE + node_ext;
  assign tx2_id = `CNEM_TX2_BASE + node_ext;
  // an object with nothing mapped is switched off by its top bit
  assign rx1_off = (i_cnt_dig_out == 4'h0);
  // the ninth digital output spills into the second receive object
  assign rx2_off = (i_cnt_dig_out <= `CNEM_DIG_PER_OBJ) && (i_cnt_ana_out == 4'h0);
  assign tx1_off = (i_cnt_dig_in == 4'h0);
  assign tx2_off = (i_cnt_ana_in4 == 4'h0) && (i_cnt_ana_in2 == 4'h0);
  // analog outputs past the fourth are ignored, not wrapped
  assign ana_out_used = (i_cnt_ana_out > `CNEM_ANA_MAX) ? `CNEM_ANA_MAX : i_cnt_ana_out;
  // history read decode: sub 0 gives the count, 1 to 10 the entries
  assign hist_sel = (i_obj_index == `CNEM_IDX_ERR_HISTORY);
  assign hist_cnt_sel = hist_sel && (i_obj_sub == `CNEM_HIST_SUBCNT);
  assign hist_ent_sel = hist_sel && (i_obj_sub <= `CNEM_HIST_SUBMAX);
  // entries are stored newest at slot zero, so sub 1 maps there
  assign hist_slot = i_obj_sub[3:0] - 4'h1;
  // defaults recompute on every start-up pulse; on changed configuration the store strobe asks
  // the nonvolatile side to overwrite what it held before
  always @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      o_defaults_store <= 1'b0;
      o_rx_cobid_flat0 <= `CNEM_COBID_OFF;
      o_rx_cobid_flat1 <= `CNEM_COBID_OFF;
      o_tx_cobid_flat0 <= `CNEM_COBID_OFF;
      o_tx_cobid_flat1 <= `CNEM_COBID_OFF;
      o_rx_map_ana_first <= 4'h0;
      o_tx_map_ana_first <= 4'h0;
    end
    else
    begin
      o_defaults_store <= start_q && i_config_changed;
      if (start_q)
      begin
        // receive side: digital outputs first, analog from object two
        o_rx_cobid_flat0 <= {rx1_off, 20'h00000, rx1_id};
        o_rx_cobid_flat1 <= {rx2_off, 20'h00000, rx2_id};
        // transmit side: digital inputs first, analog from object two; no ninth-input spill
        o_tx_cobid_flat0 <= {tx1_off, 20'h00000, tx1_id};
        o_tx_cobid_flat1 <= {tx2_off, 20'h00000, tx2_id};
        o_rx_map_ana_first <= ana_out_used;
        o_tx_map_ana_first <= i_cnt_ana_in4; // four-channel inputs first
      end
    end
  end
  // object reads; unmapped index answers with error
  always @(posedge i_mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      o_obj_rdata <= 32'h0;
      o_obj_ack <= 1'b0;
      o_obj_err <= 1'b0;
    end
    else
    begin
      o_obj_ack <= i_obj_rd || i_obj_wr;
      o_obj_err <= 1'b0;
      o_obj_rdata <= 32'h0;
      if (i_obj_rd)
      begin
        if (i_obj_index == `CNEM_IDX_ERR_SUMMARY)
          o_obj_rdata <= {24'h0, summary};
        else if (hist_cnt_sel)
          o_obj_rdata <= {28'h0, hcnt_q};
        else if (hist_ent_sel)
          o_obj_rdata <= hist_q[hist_slot];
        else if (i_obj_index == `CNEM_IDX_ERR_CLEAR)
          o_obj_rdata <= 32'h0;
        else
          o_obj_err <= 1'b1;
      end
    end
  end
endmodule // cnem_top

//--- verif/cnem_top_assertions.sv
`timescale 1ns/1ps
module cnem_top_assertions (
  // watched ports
  input wire i_mclk,
  input wire i_nrst,
  input wire [6:0] i_node_id,
  input wire i_startup_done,
  input wire i_config_changed,
  input wire i_obj_wr,
  input wire i_obj_rd,
  input wire o_obj_ack,
  input wire o_emcy_valid,
  input wire i_emcy_ready,
  input wire [10:0] o_emcy_id,
  input wire [2:0] o_emcy_len,
  input wire [39:0] o_emcy_data,
  input wire o_defaults_store,
  input wire [4:0] o_tx_rtr_allowed
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  // frame fields are judged whenever a frame is offered
  a_emcy_ident: assert property (o_emcy_valid |-> o_emcy_id == 11'h080 + i_node_id)
    else $error("bad id");
  a_frame_len: assert property (o_emcy_valid |-> o_emcy_len inside {3'h3, 3'h5})
    else $error("bad len");
  a_code_value: assert property (o_emcy_valid |-> o_emcy_data[39:24] inside {16'h0000, 16'h1000})
    else $error("bad code");
  a_generic_flag: assert property (o_emcy_valid && o_emcy_data[39:24] == 16'h1000 |-> o_emcy_data[16])
    else $error("no generic bit");
  // a stalled frame must not change under the controller
  a_frame_hold: assert property (o_emcy_valid && !i_emcy_ready |=> o_emcy_valid && $stable(o_emcy_data))
    else $error("frame moved");
  a_ack_follows: assert property (i_obj_wr || i_obj_rd |=> o_obj_ack)
    else $error("no ack");
  a_ack_cause: assert property (o_obj_ack |-> $past(i_obj_wr || i_obj_rd))
    else $error("stray ack");
  a_store_new: assert property ($rose(i_startup_done) && i_config_changed |-> ##[1:8] o_defaults_store)
    else $error("no store");
  a_rtr_five: assert property (o_tx_rtr_allowed == 5'h1f)
    else $error("bad rtr mask");
  c_stall: cover property (o_emcy_valid && !i_emcy_ready);
  c_short: cover property (o_emcy_valid && o_emcy_len == 3'h3);
  c_store: cover property (o_defaults_store);
endmodule // cnem_top_assertions

//--- verif/cnem_ctrl_model.sv
`timescale 1ns/1ps
module cnem_ctrl_model (
  // clock and pacing
  input wire i_mclk,
  input wire i_stall,
  input wire i_slow,
  // frame stream
  input wire i_valid,
  output reg o_ready,
  input wire [2:0] i_len,
  input wire [39:0] i_data,
  // last frame taken
  output reg [7:0] o_n,
  output reg [2:0] o_len,
  output reg [39:0] o_data
);
  initial o_n = 8'h00;
  initial o_ready = 1'b0;
  // ready moves on the falling edge; slow mode halves throughput
  always @(negedge i_mclk) o_ready <= !i_stall && (!i_slow || !o_ready);
  // a frame counts only where valid and ready meet
  always @(posedge i_mclk)
  begin
    if (i_valid && o_ready)
    begin
      o_n <= o_n + 8'h01;
      o_len <= i_len;
      o_data <= i_data;
    end
  end
endmodule // cnem_ctrl_model

//--- verif/can_node_emergency_and_pdo_map_tb.sv
`timescale 1ns/1ps
module can_node_emergency_and_pdo_map_tb;
  reg i_mclk = 0, i_nrst = 0, op = 1, pre = 0, sdone = 0, chg = 0, bus = 0, wr = 0, rd = 0, stall = 0, slow = 0;
  reg [6:0] node = 7'd42; // highest node number allowed
  reg [7:0] cpu = 0, sub = 0, n0;
  reg [4:0] modf = 0;
  reg [15:0] idx = 0;
  reg [31:0] wd = 0, rdat;
  reg [3:0] cnt = 4'h3;
  reg got_err, stored;
  integer mismatches = 0, n_tests = 0, k;
  wire ack, err, vld, rdy, store;
  wire [31:0] rdata;
  wire [10:0] id;
  wire [2:0] len, m_len;
  wire [39:0] dat, m_dat;
  wire [7:0] m_n;
  wire [4:0] rtr;
  wire [31:0] rx0, rx1, tx0, tx1;
  wire [3:0] rxa, txa;
  wire ovf;
  cnem_top uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_node_id(node), .i_node_operational(op), .i_node_preop(pre),
    .i_startup_done(sdone), .i_config_changed(chg), .i_slots_dig_out(2'h0), .i_cnt_dig_out(cnt), .i_cnt_dig_in(cnt),
    .i_cnt_ana_out(cnt), .i_cnt_ana_in4(cnt), .i_cnt_ana_in2(cnt), .i_cpu_err_set(cpu), .i_mod_err_set(modf),
    .i_bus_err_set(bus), .i_obj_wr(wr), .i_obj_rd(rd), .i_obj_index(idx), .i_obj_sub(sub), .i_obj_wdata(wd),
    .o_obj_rdata(rdata), .o_obj_ack(ack), .o_obj_err(err), .o_emcy_valid(vld), .i_emcy_ready(rdy), .o_emcy_id(id),
    .o_emcy_len(len), .o_emcy_data(dat), .o_emcy_overflow(ovf), .o_defaults_store(store), .o_rx_cobid_flat0(rx0),
    .o_rx_cobid_flat1(rx1), .o_tx_cobid_flat0(tx0), .o_tx_cobid_flat1(tx1), .o_rx_map_ana_first(rxa),
    .o_tx_map_ana_first(txa), .o_tx_rtr_allowed(rtr));
  cnem_ctrl_model m (.i_mclk(i_mclk), .i_stall(stall), .i_slow(slow), .i_valid(vld), .o_ready(rdy), .i_len(len),
    .i_data(dat), .o_n(m_n), .o_len(m_len), .o_data(m_dat));
  initial forever #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
      stored <= 1'b0;
    else if (store)
      stored <= 1'b1;
  task chk(input [39:0] seen, input [39:0] exp, input [63:0] what);
  begin
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("wrong value %0s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  // one object access; answer awaited for a few cycles only
  task obj(input w, input [15:0] i, input [7:0] s, input [31:0] d);
  begin
    @(negedge i_mclk);
    {wr, rd, idx, sub, wd} = {w, !w, i, s, d};
    @(negedge i_mclk);
    {wr, rd, got_err} = 3'b000;
    for (k = 0; k < 4 && !ack && !err; k = k + 1) @(negedge i_mclk);
    got_err = err;
    rdat = rdata;
  end
  endtask
  task ev(input [7:0] c, input [4:0] mo, input b);
  begin
    n0 = m_n;
    @(negedge i_mclk);
    {cpu, modf, bus} = {c, mo, b};
    @(negedge i_mclk);
    {cpu, modf, bus} = 14'h0;
  end
  endtask
  task wait_frame;
    for (k = 0; k < 60 && m_n == n0; k = k + 1) @(negedge i_mclk);
  endtask
  // restart, raise start-up and judge the first frame
  task t_start(input c, input [2:0] el, input [39:0] ed);
  begin
    {i_nrst, sdone, chg} = {2'b00, c};
    repeat (6) @(negedge i_mclk);
    i_nrst = 1;
    repeat (3) @(negedge i_mclk);
    n0 = m_n;
    sdone = 1;
    wait_frame;
    chk(m_len, el, "len");
    chk(c ? m_dat : {m_dat[39:16], 16'h0}, ed, "start");
    chk(stored, c, "store");
    chk(rtr, 5'h1f, "rtr");
    chk(rx0, 32'h0000022a, "rx0");
    chk(rx1, 32'h0000032a, "rx1");
    chk(tx0, 32'h000001aa, "tx0");
    chk(tx1, 32'h000002aa, "tx1");
    chk(rxa, 4'h3, "rxa");
    chk(txa, 4'h3, "txa");
    $display("start test done");
  end
  endtask
  task t_bus;
  begin
    stall = 1;
    ev(0, 0, 1);
    repeat (6) @(negedge i_mclk);
    stall = 0;
    wait_frame;
    chk(m_dat[39:16], 24'h100011, "code");
    obj(0, 16'h1001, 0, 0);
    chk(rdat[4], 1, "sum");
    obj(1, 16'h5000, 0, 32'h00ff); // partial clear keeps bus flag
    obj(0, 16'h1001, 0, 0);
    chk(rdat[4], 1, "keep");
    obj(1, 16'h5000, 0, 32'hffff);
    obj(0, 16'h1001, 0, 0);
    chk(rdat[4], 0, "clr");
    $display("bus test done");
  end
  endtask
  task t_hist;
  begin
    slow = 1;
    for (k = 0; k < 11; k = k + 1) ev(8'h01, 0, 0);
    obj(0, 16'h1003, 0, 0);
    chk(rdat, 10, "count");
    obj(0, 16'h1003, 1, 0);
    chk(rdat, 32'h01001000, "h1");
    obj(1, 16'h5000, 0, 32'h0100);
    ev(0, 5'h02, 0);
    obj(0, 16'h1003, 1, 0);
    chk(rdat, 32'h00021000, "newest");
    obj(0, 16'h1003, 2, 0);
    chk(rdat, 32'h01001000, "shift");
    slow = 0;
    $display("history test done");
  end
  endtask
  task t_state;
  begin
    op = 0;
    ev(0, 0, 1);
    repeat (20) @(negedge i_mclk);
    chk(m_n, n0, "idle");
    pre = 1;
    ev(0, 0, 1);
    wait_frame;
    chk(m_n, n0 + 8'h01, "preop");
    obj(0, 16'h2000, 0, 0);
    chk(got_err, 1, "unmap");
    // fill the 32-frame queue while the controller stalls, then one more
    stall = 1;
    for (k = 0; k < 32; k = k + 1) ev(0, 0, 1);
    @(negedge i_mclk);
    bus = 1;
    #1;
    chk(ovf, 1, "ovf");
    @(negedge i_mclk);
    {bus, stall} = 2'b00;
    $display("state test done");
  end
  endtask
  task report_and_stop;
  begin
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    t_start(0, 3'h3, 40'h0);
    t_start(1, 3'h5, 40'h1000018000);
    t_bus;
    t_hist;
    t_state;
    report_and_stop;
  end
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    report_and_stop;
  end
endmodule // can_node_emergency_and_pdo_map_tb
bind cnem_top cnem_top_assertions u_chk (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_node_id(i_node_id),
  .i_startup_done(i_startup_done), .i_config_changed(i_config_changed), .i_obj_wr(i_obj_wr), .i_obj_rd(i_obj_rd),
  .o_obj_ack(o_obj_ack), .o_emcy_valid(o_emcy_valid), .i_emcy_ready(i_emcy_ready), .o_emcy_id(o_emcy_id),
  .o_emcy_len(o_emcy_len), .o_emcy_data(o_emcy_data), .o_defaults_store(o_defaults_store),
  .o_tx_rtr_allowed(o_tx_rtr_allowed));
